/* File: logic/se_host.sv */
// Master end of the two-wire link with write data FIFO
`timescale 1ns/1ps
`include "se_map.svh"

// ----------------------------------------
// Valid/ready FIFO
// ----------------------------------------
module se_fifo #(
  parameter int W = 8, // Word width
  parameter int DEPTH = 32 // Words, power of two
) (
  input wire logic clk_i, // System clock
  input wire logic rst_b_i, // Sync reset, active low
  input wire logic in_valid_i, // Word offered
  input wire logic [W-1:0] in_data_i, // Word in
  output logic in_ready_o, // Room left
  output logic out_valid_o, // Word held
  output logic [W-1:0] out_data_o, // Word out
  input wire logic out_ready_i // Word taken
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;
  logic [AW:0] cnt;
  logic [AW:0] next_cnt;
  logic push;
  logic pop;
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;
  assign next_cnt = cnt + (AW+1)'(push) - (AW+1)'(pop);
  assign out_valid_o = cnt != '0;
  assign out_data_o = mem[rp];
  // Storage
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wp] <= in_data_i;
    end
  end
  // Pointers, fill level and registered ready
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      wp <= '0;
      rp <= '0;
      cnt <= '0;
      in_ready_o <= 1'b1;
    end else begin
      wp <= wp + AW'(push);
      rp <= rp + AW'(pop);
      cnt <= next_cnt;
      in_ready_o <= next_cnt != (AW+1)'(DEPTH);
    end
  end
endmodule : se_fifo

// ----------------------------------------
// Bus master end
// ----------------------------------------
module se_host
  import se_pkg::*;
(
  input wire logic CLK_I, // System clock, 40 MHz
  input wire logic RST_B_I, // Sync reset, active low
  se_if.host BUS, // Two-wire link
  input wire logic CMD_VALID_I, // Command offered
  input wire se_op_t CMD_OP_I, // Operation
  input wire logic [11:0] CMD_ADDR_I, // Memory address
  input wire logic [7:0] CMD_LEN_I, // Data byte count
  output logic CMD_READY_O, // Idle, command taken
  input wire logic WR_VALID_I, // Write byte offered
  input wire logic [7:0] WR_DATA_I, // Write byte
  output logic WR_READY_O, // FIFO has room
  output logic RD_VALID_O, // Read byte pulse
  output logic [7:0] RD_DATA_O, // Read byte
  output logic DONE_O, // Operation finished pulse
  output logic NACK_O // Last operation refused
);
  se_hst_t state;
  se_hrole_t role;
  se_op_t op;
  logic [11:0] addr;
  logic [7:0] len;
  logic [1:0] ph;
  logic [3:0] b;
  logic [7:0] sh;
  logic [7:0] txv;
  logic drv;
  logic akb;
  logic sda;
  logic scl_oe_b;
  logic sda_oe_b;
  logic [`SE_QTR_W-1:0] qcnt;
  logic tick;
  logic stall;
  logic f_valid;
  logic [7:0] f_data;
  logic f_pop;

  se_sync u_sda (.clk_i(CLK_I), .rst_b_i(RST_B_I), .d_i(BUS.sda), .q_o(sda));

  se_fifo #(.W(`SE_FIFO_W), .DEPTH(`SE_FIFO_DEPTH)) u_fifo (
    .clk_i(CLK_I),
    .rst_b_i(RST_B_I),
    .in_valid_i(WR_VALID_I),
    .in_data_i(WR_DATA_I),
    .in_ready_o(WR_READY_O),
    .out_valid_o(f_valid),
    .out_data_o(f_data),
    .out_ready_i(f_pop)
  );

  // Quarter bit divider for the generated clock
  always_ff @(posedge CLK_I) begin
    if (!RST_B_I || state == H_IDLE || tick) begin
      qcnt <= '0;
    end else begin
      qcnt <= qcnt + `SE_QTR_W'(1);
    end
  end
  assign tick = qcnt == `SE_QTR_W'(`SE_QTR_CYC - 1);
  assign stall = role == HR_WD && b == 4'h0 && ph == 2'h0 && !f_valid;
  assign f_pop = state == H_BIT && tick && ph == 2'h0 && b == 4'h0 && role == HR_WD && f_valid;

  // Byte to send and level to drive for the current bit
  always_comb begin
    txv = sh;
    if (b == 4'h0) begin
      case (role)
        HR_AW: txv = {`SE_DEV_TYPE, 3'h0, 1'b0};
        HR_AHI: txv = {4'h0, addr[11:8]};
        HR_ALO: txv = addr[7:0];
        HR_WD: txv = f_data;
        HR_AR: txv = {`SE_DEV_TYPE, 3'h0, 1'b1};
        default: txv = 8'hff;
      endcase
    end
    if (b == 4'h8) begin
      drv = (role == HR_RD) ? (len <= 8'h01) : 1'b1;
    end else begin
      drv = (role == HR_RD) ? 1'b1 : txv[7];
    end
  end

  // Command sequencer and bit engine
  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      state <= H_IDLE;
      role <= HR_AW;
      op <= OP_WRITE;
      addr <= 12'h000;
      len <= 8'h00;
      ph <= 2'h0;
      b <= 4'h0;
      sh <= 8'h00;
      akb <= 1'b1;
      scl_oe_b <= 1'b1;
      sda_oe_b <= 1'b1;
      CMD_READY_O <= 1'b1;
      RD_VALID_O <= 1'b0;
      RD_DATA_O <= 8'h00;
      DONE_O <= 1'b0;
      NACK_O <= 1'b0;
    end else begin
      RD_VALID_O <= 1'b0;
      DONE_O <= 1'b0;
      case (state)
        H_IDLE: begin
          if (CMD_VALID_I) begin
            op <= CMD_OP_I;
            addr <= CMD_ADDR_I;
            len <= CMD_LEN_I;
            ph <= 2'h0;
            CMD_READY_O <= 1'b0;
            NACK_O <= 1'b0;
            role <= (CMD_OP_I == OP_READ) ? HR_AR : HR_AW;
            state <= H_START;
          end
        end
        H_START: begin
          if (tick) begin
            ph <= ph + 2'h1;
            case (ph)
              2'h0: sda_oe_b <= 1'b1;
              2'h1: scl_oe_b <= 1'b1;
              2'h2: sda_oe_b <= 1'b0;
              default: begin
                scl_oe_b <= 1'b0;
                b <= 4'h0;
                state <= H_BIT;
              end
            endcase
          end
        end
        H_BIT: begin
          if (tick && !stall) begin
            ph <= ph + 2'h1;
            case (ph)
              2'h0: begin
                if (b == 4'h0) begin
                  sh <= txv;
                end
                sda_oe_b <= drv;
              end
              2'h1: scl_oe_b <= 1'b1;
              2'h2: begin
                if (b == 4'h8) begin
                  akb <= sda;
                end else begin
                  sh <= {sh[6:0], sda};
                end
              end
              default: begin
                scl_oe_b <= 1'b0;
                b <= b + 4'h1;
                if (b == 4'h8) begin
                  b <= 4'h0;
                  if (role == HR_RD) begin
                    RD_VALID_O <= 1'b1;
                    RD_DATA_O <= sh;
                    len <= len - 8'h01;
                    if (len <= 8'h01) begin
                      state <= H_STOP;
                    end
                  end else if (akb) begin
                    NACK_O <= 1'b1;
                    state <= H_STOP;
                  end else begin
                    case (role)
                      HR_AW: begin
                        if (op == OP_POLL) begin
                          state <= H_STOP;
                        end else begin
                          role <= HR_AHI;
                        end
                      end
                      HR_AHI: role <= HR_ALO;
                      HR_ALO: begin
                        if (op == OP_RAND) begin
                          role <= HR_AR;
                          state <= H_START;
                        end else if (len == 8'h00) begin
                          state <= H_STOP;
                        end else begin
                          role <= HR_WD;
                        end
                      end
                      HR_WD: begin
                        len <= len - 8'h01;
                        if (len <= 8'h01) begin
                          state <= H_STOP;
                        end
                      end
                      default: role <= HR_RD;
                    endcase
                  end
                end
              end
            endcase
          end
        end
        H_STOP: begin
          if (tick) begin
            ph <= ph + 2'h1;
            case (ph)
              2'h0: sda_oe_b <= 1'b0;
              2'h1: scl_oe_b <= 1'b1;
              2'h2: sda_oe_b <= 1'b1;
              default: begin
                DONE_O <= 1'b1;
                CMD_READY_O <= 1'b1;
                state <= H_IDLE;
              end
            endcase
          end
        end
        default: state <= H_IDLE;
      endcase
    end
  end

  // Open-drain drive, low only
  assign BUS.host_scl_o = 1'b0;
  assign BUS.host_sda_o = 1'b0;
  assign BUS.host_scl_oe_b = scl_oe_b;
  assign BUS.host_sda_oe_b = sda_oe_b;
endmodule : se_host

/* File: logic/se_map.svh */
// Constants of the serial EEPROM two-wire link
`ifndef SE_MAP_SVH
`define SE_MAP_SVH
`define SE_DEV_TYPE 4'ha
`define SE_ADDR_W 12
`define SE_PAGE_W 6
`define SE_PAGE_LAST 6'h3f
`define SE_MEM_DEPTH 4096
`define SE_FIFO_W 8
`define SE_FIFO_DEPTH 32
`define SE_CLK_NS 25
`define SE_TWR_NS 5000000
`define SE_TWR_CYC ((`SE_TWR_NS + `SE_CLK_NS - 1) / `SE_CLK_NS)
`define SE_TMR_W 18
`define SE_SCL_NS 2500
`define SE_QTR_CYC (`SE_SCL_NS / 4 / `SE_CLK_NS)
`define SE_QTR_W 5
`endif

/* File: logic/se_pkg.sv */
// Types shared by both ends of the serial EEPROM link
package se_pkg;
  // Device end protocol states
  typedef enum logic [5:0] {
    D_IDLE = 6'h01,
    D_RX = 6'h02,
    D_ACK = 6'h04,
    D_TX = 6'h08,
    D_RACK = 6'h10,
    D_WSTOP = 6'h20
  } se_dst_t;
  // Meaning of the next received byte
  typedef enum logic [1:0] {
    R_DEV = 2'h0,
    R_AHI = 2'h1,
    R_ALO = 2'h2,
    R_DATA = 2'h3
  } se_drole_t;
  // Master end states
  typedef enum logic [3:0] {
    H_IDLE = 4'h1,
    H_START = 4'h2,
    H_BIT = 4'h4,
    H_STOP = 4'h8
  } se_hst_t;
  // Meaning of the byte the master moves
  typedef enum logic [2:0] {
    HR_AW = 3'h0,
    HR_AHI = 3'h1,
    HR_ALO = 3'h2,
    HR_WD = 3'h3,
    HR_AR = 3'h4,
    HR_RD = 3'h5
  } se_hrole_t;
  // Master commands
  typedef enum logic [1:0] {
    OP_WRITE = 2'h0,
    OP_READ = 2'h1,
    OP_RAND = 2'h2,
    OP_POLL = 2'h3
  } se_op_t;
endpackage : se_pkg

/* File: logic/se_if.sv */
// Two-wire link joining master and EEPROM ends
`timescale 1ns/1ps
interface se_if;
  logic scl; // Resolved clock line
  logic sda; // Resolved data line
  logic host_scl_o;
  logic host_scl_oe_b;
  logic host_sda_o;
  logic host_sda_oe_b;
  logic dev_sda_o;
  logic dev_sda_oe_b;
  // Open-drain lines with pull-up
  assign scl = host_scl_oe_b | host_scl_o;
  assign sda = (host_sda_oe_b | host_sda_o) & (dev_sda_oe_b | dev_sda_o);
  modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe_b);
  modport host (input scl, input sda, output host_scl_o, output host_scl_oe_b,
                output host_sda_o, output host_sda_oe_b);
endinterface : se_if

/* File: logic/se_dev.sv */
// EEPROM end of the two-wire link with page buffer and array
`timescale 1ns/1ps
// Function
// - SDA fall, SCL high starts; idle until
// - SDA rise, SCL high stops
// - Master ends every operation with stop
// - Upper address nibble matches device type
// - Address LSB one reads, zero writes
// - Matching address acknowledged, then operation runs
// - Receiver pulls SDA low on ninth clock
// - Every written byte acknowledged
// - Shift eight bits, release, continue on ack
// - Master no-ack ends sending until stop
// - Byte write: address, two pointers, data, stop
// - Stop after write programs; bus ignored meanwhile
// - Up to 64 bytes programmed together
// - Write increments only in-page address bits
// - Over 64 bytes wraps and overwrites
// - Busy device withholds address acknowledge
// - Counter holds last accessed address plus one
// - Counter rolls from 4095 to zero
// - Current read: ack, one byte, no-ack, stop
// - Random read: dummy write, repeated start, read
// - Sequential read increments full address
`include "se_map.svh"

// ----------------------------------------
// Input synchroniser with agreement filter
// ----------------------------------------
module se_sync (
  input wire logic clk_i, // System clock
  input wire logic rst_b_i, // Sync reset, active low
  input wire logic d_i, // Asynchronous input
  output logic q_o // Filtered level
);
  logic s1;
  logic s2;
  logic s3;
  // Three stages, change taken when last two agree
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      s1 <= 1'b1;
      s2 <= 1'b1;
      s3 <= 1'b1;
      q_o <= 1'b1;
    end else begin
      s1 <= d_i;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        q_o <= s3;
      end
    end
  end
endmodule : se_sync

// ----------------------------------------
// EEPROM device end
// ----------------------------------------
module se_dev
  import se_pkg::*;
#(
  parameter int unsigned TWR_CYC = `SE_TWR_CYC // Programming cycle length
) (
  input wire logic CLK_I, // System clock, 40 MHz
  input wire logic RST_B_I, // Sync reset, active low
  se_if.dev BUS, // Two-wire link
  output logic BUSY_O, // Programming cycle running
  output logic [11:0] ADDR_O // Address counter
);
  logic scl;
  logic sda;
  logic scl_d;
  logic sda_d;
  logic scl_rise;
  logic scl_fall;
  logic start;
  logic stop;
  se_dst_t state;
  se_drole_t role;
  logic [3:0] cnt;
  logic [7:0] sh;
  logic [3:0] ahi;
  logic [11:0] ctr;
  logic rd;
  logic mack;
  logic oe_b;
  logic wrote;
  logic byte_end;
  logic addr_hit;
  logic buf_we;
  logic prog_go;
  logic busy;
  logic [`SE_TMR_W-1:0] tmr;
  logic [5:0] cidx;
  logic commit;
  logic [5:0] page;
  logic [63:0] pmask;
  logic [7:0] pbuf [64];
  logic [7:0] mem [`SE_MEM_DEPTH];
  logic [7:0] rdat;

  // Line synchronisers
  se_sync u_scl (.clk_i(CLK_I), .rst_b_i(RST_B_I), .d_i(BUS.scl), .q_o(scl));
  se_sync u_sda (.clk_i(CLK_I), .rst_b_i(RST_B_I), .d_i(BUS.sda), .q_o(sda));

  // Previous filtered levels for edge finding
  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl;
      sda_d <= sda;
    end
  end

  // Line events
  assign scl_rise = scl & ~scl_d;
  assign scl_fall = ~scl & scl_d;
  assign start = scl & scl_d & sda_d & ~sda;
  assign stop = scl & scl_d & ~sda_d & sda;
  assign byte_end = (state == D_RX) && scl_fall && (cnt == 4'h8);
  assign addr_hit = (sh[7:4] == `SE_DEV_TYPE) && !busy;
  assign buf_we = byte_end && (role == R_DATA);
  assign prog_go = stop && wrote;
  assign commit = busy && (tmr == '0);
  assign rdat = mem[ctr];

  // Byte level protocol
  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      state <= D_IDLE;
      role <= R_DEV;
      cnt <= 4'h0;
      sh <= 8'h00;
      ahi <= 4'h0;
      ctr <= 12'h000;
      rd <= 1'b0;
      mack <= 1'b0;
      oe_b <= 1'b1;
    end else if (start) begin
      state <= D_RX;
      role <= R_DEV;
      cnt <= 4'h0;
      oe_b <= 1'b1;
    end else if (stop) begin
      state <= D_IDLE;
      oe_b <= 1'b1;
    end else begin
      case (state)
        D_RX: begin
          if (scl_rise) begin
            sh <= {sh[6:0], sda};
            cnt <= cnt + 4'h1;
          end
          if (byte_end) begin
            if (role != R_DEV || addr_hit) begin
              oe_b <= 1'b0;
              state <= D_ACK;
            end else begin
              state <= D_IDLE;
            end
            case (role)
              R_DEV: rd <= sh[0];
              R_AHI: ahi <= sh[3:0];
              R_ALO: ctr <= {ahi, sh};
              default: ctr <= {ctr[11:6], ctr[5:0] + 6'h01};
            endcase
          end
        end
        D_ACK: begin
          if (scl_fall) begin
            cnt <= 4'h0;
            if (role == R_DEV && rd) begin
              sh <= rdat;
              oe_b <= rdat[7];
              ctr <= ctr + 12'h001;
              state <= D_TX;
            end else begin
              oe_b <= 1'b1;
              state <= D_RX;
              case (role)
                R_DEV: role <= R_AHI;
                R_AHI: role <= R_ALO;
                default: role <= R_DATA;
              endcase
            end
          end
        end
        D_TX: begin
          if (scl_fall) begin
            if (cnt == 4'h7) begin
              oe_b <= 1'b1;
              state <= D_RACK;
            end else begin
              oe_b <= sh[6];
              sh <= {sh[6:0], 1'b0};
              cnt <= cnt + 4'h1;
            end
          end
        end
        D_RACK: begin
          if (scl_rise) begin
            mack <= ~sda;
          end
          if (scl_fall) begin
            cnt <= 4'h0;
            if (mack) begin
              sh <= rdat;
              oe_b <= rdat[7];
              ctr <= ctr + 12'h001;
              state <= D_TX;
            end else begin
              state <= D_WSTOP;
            end
          end
        end
        D_WSTOP: state <= D_WSTOP;
        default: state <= D_IDLE;
      endcase
    end
  end

  // Data received since the last stop
  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      wrote <= 1'b0;
    end else if (stop) begin
      wrote <= 1'b0;
    end else if (buf_we) begin
      wrote <= 1'b1;
    end
  end

  // Page buffer, later bytes overwrite earlier ones
  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      pmask <= 64'h0000_0000_0000_0000;
      page <= 6'h00;
    end else if (buf_we) begin
      pbuf[ctr[5:0]] <= sh;
      pmask[ctr[5:0]] <= 1'b1;
      page <= ctr[11:6];
    end else if (commit && cidx == `SE_PAGE_LAST) begin
      pmask <= 64'h0000_0000_0000_0000;
    end
  end

  // Programming cycle timer and page commit walk
  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      busy <= 1'b0;
      tmr <= '0;
      cidx <= 6'h00;
    end else if (prog_go) begin
      busy <= 1'b1;
      tmr <= `SE_TMR_W'(TWR_CYC - 1);
      cidx <= 6'h00;
    end else if (busy) begin
      if (tmr != '0) begin
        tmr <= tmr - `SE_TMR_W'(1);
      end else if (cidx == `SE_PAGE_LAST) begin
        busy <= 1'b0;
      end else begin
        cidx <= cidx + 6'h01;
      end
    end
  end

  // Array write, one buffered byte per cycle
  always_ff @(posedge CLK_I) begin
    if (commit && pmask[cidx]) begin
      mem[{page, cidx}] <= pbuf[cidx];
    end
  end

  // Link and status outputs
  assign BUS.dev_sda_o = 1'b0;
  assign BUS.dev_sda_oe_b = oe_b;
  assign BUSY_O = busy;
  assign ADDR_O = ctr;
endmodule : se_dev

/* File: testbench/se_link_sva.sv */
// Checker watching the two-wire link between master and EEPROM ends
`timescale 1ns/1ps
module se_link_sva #(
  parameter int unsigned TWR_CYC = 200000 // Programming cycle length
) (
  input wire logic CLK_I, // System clock
  input wire logic RST_B_I, // Sync reset, active low
  input wire logic scl, // Resolved clock line
  input wire logic sda, // Resolved data line
  input wire logic dev_sda_oe_b, // Device data enable, active low
  input wire logic BUSY_O // Programming cycle running
);
  logic framed;
  logic [7:0] since_stop;
  logic [31:0] busy_cnt;

  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RST_B_I);

  // ----------------------------------------
  // Helper logic
  // ----------------------------------------
  // Frame open between a start and a stop on the wire
  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) framed <= 1'b0;
    else if (scl && $fell(sda)) framed <= 1'b1;
    else if (scl && $rose(sda)) framed <= 1'b0;
  end
  // Cycles since the last stop, saturating
  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) since_stop <= 8'hff;
    else if (scl && $rose(sda)) since_stop <= 8'h00;
    else if (since_stop != 8'hff) since_stop <= since_stop + 8'h01;
  end
  // Length of the busy span
  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) busy_cnt <= 32'h0000_0000;
    else if (BUSY_O) busy_cnt <= busy_cnt + 32'h0000_0001;
    else busy_cnt <= 32'h0000_0000;
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  chk_dev_sda_stable: assert property ($changed(dev_sda_oe_b) |-> !scl)
    else $error("device moved data while clock high");
  chk_idle_quiet: assert property (!dev_sda_oe_b |-> framed)
    else $error("device drove data outside a frame");
  chk_idle_clock: assert property (!framed |-> scl)
    else $error("clock low outside a frame");
  chk_busy_no_ack: assert property (BUSY_O |-> dev_sda_oe_b)
    else $error("device answered while busy");
  // Timer loads TWR_CYC-1, then 64 commit cycles: busy for TWR_CYC+63 cycles
  chk_busy_span: assert property ($fell(BUSY_O) |-> busy_cnt == TWR_CYC + 63)
    else $error("busy span has wrong length");
  chk_busy_after_stop: assert property ($rose(BUSY_O) |-> since_stop <= 8'h0a)
    else $error("programming began without a stop");
  chk_ack_hold: assert property ($fell(dev_sda_oe_b) |-> !dev_sda_oe_b [*8])
    else $error("device pull too short");
  chk_pull_spans_high: assert property ($fell(dev_sda_oe_b) |->
    ##[1:60] (scl && !dev_sda_oe_b))
    else $error("device pull missed the clock high");
endmodule : se_link_sva

/* File: testbench/test_serial_eeprom_i2c_slave.sv */
// Self-checking bench joining the master and EEPROM ends
`timescale 1ns/1ps
module test_serial_eeprom_i2c_slave;
  import se_pkg::*;
  localparam int TWR = 3000; // Shortened programming time
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic cmd_valid = 1'b0;
  se_op_t cmd_op = OP_WRITE;
  logic [11:0] cmd_addr = 12'h000;
  logic [7:0] cmd_len = 8'h00;
  logic wr_valid = 1'b0;
  logic [7:0] wr_data = 8'h00;
  logic cmd_ready, wr_ready, rd_valid, done, nack, busy;
  logic [7:0] rd_data;
  logic [11:0] addr_cnt;
  logic [7:0] mem [0:4095];
  logic [7:0] rd_q [$];
  int error_cnt = 0;
  int cmp_count = 0;

  se_if link ();
  se_dev #(.TWR_CYC(TWR)) se_dev_inst (.CLK_I(clk), .RST_B_I(rst_b), .BUS(link),
    .BUSY_O(busy), .ADDR_O(addr_cnt));
  se_host se_host_inst (.CLK_I(clk), .RST_B_I(rst_b), .BUS(link), .CMD_VALID_I(cmd_valid),
    .CMD_OP_I(cmd_op), .CMD_ADDR_I(cmd_addr), .CMD_LEN_I(cmd_len), .CMD_READY_O(cmd_ready),
    .WR_VALID_I(wr_valid), .WR_DATA_I(wr_data), .WR_READY_O(wr_ready), .RD_VALID_O(rd_valid),
    .RD_DATA_O(rd_data), .DONE_O(done), .NACK_O(nack));
  se_link_sva #(.TWR_CYC(TWR)) se_link_sva_inst (.CLK_I(clk), .RST_B_I(rst_b), .scl(link.scl),
    .sda(link.sda), .dev_sda_oe_b(link.dev_sda_oe_b), .BUSY_O(busy));

  // 40 MHz clock
  initial begin
    forever #12.5 clk = ~clk;
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task conclude;
    $display("Comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : conclude

  // One byte into the write FIFO
  task push(input logic [7:0] b);
    @(negedge clk);
    wr_valid = 1'b1;
    wr_data = b;
    @(posedge clk);
    while (wr_ready !== 1'b1) @(posedge clk);
    @(negedge clk);
    wr_valid = 1'b0;
  endtask : push

  // One command, collecting read bytes until done
  task run(input se_op_t op, input logic [11:0] a, input logic [7:0] n);
    int k;
    rd_q.delete();
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_addr = a;
    cmd_len = n;
    @(posedge clk);
    while (cmd_ready !== 1'b1) @(posedge clk);
    @(negedge clk);
    cmd_valid = 1'b0;
    for (k = 0; k < 20000; k++) begin
      @(negedge clk);
      if (rd_valid === 1'b1) rd_q.push_back(rd_data);
      if (done === 1'b1) break;
    end
    check("done", done, 16'h0001);
  endtask : run

  // Page write, then acknowledge polling until ready
  task wr_page(input logic [11:0] a, input int n, input logic [7:0] seed);
    int i;
    int polls;
    for (i = 0; i < n; i++) begin
      push(seed + i[7:0]);
      mem[{a[11:6], a[5:0] + i[5:0]}] = seed + i[7:0];
    end
    run(OP_WRITE, a, n[7:0]);
    check("write nack", nack, 16'h0000);
    check("page addr", addr_cnt, {a[11:6], a[5:0] + n[5:0]});
    run(OP_POLL, 12'h000, 8'h00);
    check("busy", busy, 16'h0001);
    check("poll busy", nack, 16'h0001);
    polls = 0;
    while (nack === 1'b1 && polls < 10) begin
      run(OP_POLL, 12'h000, 8'h00);
      polls++;
    end
    check("poll ready", nack, 16'h0000);
  endtask : wr_page

  // Read n bytes expected from address a onward
  task rd(input se_op_t op, input logic [11:0] a, input int n);
    int i;
    run(op, a, n[7:0]);
    check("read nack", nack, 16'h0000);
    check("read count", 16'(rd_q.size()), n[15:0]);
    for (i = 0; i < n; i++) check("read data", rd_q[i], mem[12'(a + i[11:0])]);
    check("counter", addr_cnt, 12'(a + n[11:0]));
  endtask : rd

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    repeat (4) @(negedge clk);
    rst_b = 1'b1;
    wr_page(12'h13e, 4, 8'ha0);
    wr_page(12'hfff, 1, 8'hb0);
    wr_page(12'h000, 1, 8'hc0);
    rd(OP_RAND, 12'hfff, 2);
    rd(OP_RAND, 12'h100, 2);
    rd(OP_RAND, 12'h13e, 1);
    rd(OP_READ, 12'h13f, 1);
    run(OP_WRITE, 12'h000, 8'h00);
    check("pointer only busy", busy, 16'h0000);
    rd(OP_READ, 12'h000, 1);
    conclude();
  end

  // Watchdog against a hung link
  initial begin
    #2_400_000;
    error_cnt++;
    $display("Error watchdog expired");
    conclude();
  end
endmodule : test_serial_eeprom_i2c_slave
